// file: hw/filt_field_sel.sv
// Filter field select with classic Wishbone control register.
// Summary of operation
// - Seven-bit cutoff code from control register drives the filter as written.
// - Cutoff code gives at most 128 steps.
// - Data slimming code 111 least peaking, 000 most, monotonic.
// - Data field keeps injection ratio at or above minimum.
// - One control bit, bit 12, enables field bandwidth switching.
// - Field select low means data field, high means servo field.
// - Enabled and servo field selects servo slimming code, ratio may reach zero.
// - Field settings switch by pin alone, no register write.
// - Servo slimming code decodes to same eight peaking levels.
// - Field select always steers gain control between gain pins.
// - Unselected gain pin is held so stored gain is kept.
`include "filt_sel_params.svh"
module filt_field_sel (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_field_select_pin,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	output logic [6:0] o_cutoff_code,
	output logic [2:0] o_slim_code,
	output logic [2:0] o_peak_idx,
	output logic [4:0] o_k_ratio,
	output logic o_data_gain_ctrl_pin,
	output logic o_alt_field_gain_ctrl_pin,
	output logic o_data_gain_hold,
	output logic o_alt_field_gain_hold
);
	////////////////////////////////////////////////////////////////////////
	// Pin synchroniser.
	logic fs_meta;
	logic fs_sync;
	logic next_fs_meta;
	logic next_fs_sync;
	always_comb begin
		next_fs_meta = i_field_select_pin;
		next_fs_sync = fs_meta;
	end
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			fs_meta <= 1'b0;
			fs_sync <= 1'b0;
		end else begin
			fs_meta <= next_fs_meta;
			fs_sync <= next_fs_sync;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Control register and Wishbone slave.
	logic [31:0] ctrl;
	logic [31:0] next_ctrl;
	logic [31:0] next_rdat;
	logic next_ack;
	logic [31:0] wmask;
	logic hit_ctrl;
	logic hit_stat;
	filt_sel_pkg::field_t field;
	filt_sel_pkg::filt_out_t fo;
	filt_sel_pkg::filt_out_t next_fo;
	always_comb begin
		wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
		hit_ctrl = (i_wb_adr == `REG_CTRL_ADDR);
		hit_stat = (i_wb_adr == `REG_STAT_ADDR);
		next_ack = i_wb_cyc && i_wb_stb && !o_wb_ack;
		next_ctrl = ctrl;
		if (next_ack && i_wb_we && hit_ctrl) begin
			next_ctrl = (ctrl & ~wmask) | (i_wb_dat & wmask);
		end
		next_rdat = 32'h0000_0000;
		if (next_ack && !i_wb_we) begin
			if (hit_ctrl) begin
				next_rdat = ctrl & 32'h0000_FFFF;
			end else if (hit_stat) begin
				next_rdat = {14'h0000, fo};
			end
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ctrl <= `CTRL_RESET;
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0000_0000;
		end else begin
			ctrl <= next_ctrl;
			o_wb_ack <= next_ack;
			o_wb_dat <= next_rdat;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Field selection and slimming decode.
	logic alt_active;
	logic [2:0] eff_code;
	logic [2:0] dec_peak;
	logic [4:0] dec_k;
	always_comb begin
		// Pin high is the servo field.
		field = fs_sync ? filt_sel_pkg::FIELD_ALT : filt_sel_pkg::FIELD_DATA;
		alt_active = ctrl[`SWITCH_EN_BIT] && (field == filt_sel_pkg::FIELD_ALT);
		eff_code = alt_active ? ctrl[`ALT_SLIM_MSB:`ALT_SLIM_LSB]
			: ctrl[`DATA_SLIM_MSB:`DATA_SLIM_LSB];
	end
	slim_decode u_dec (
		.i_code(eff_code),
		.i_allow_zero(alt_active),
		.o_peak_idx(dec_peak),
		.o_k_ratio(dec_k)
	);
	always_comb begin
		next_fo.cutoff_code = ctrl[`CUTOFF_MSB:`CUTOFF_LSB];
		next_fo.slim_code = eff_code;
		next_fo.k_ratio = dec_k;
		next_fo.gain_sel_alt = (field == filt_sel_pkg::FIELD_ALT);
		next_fo.hold_data = (field == filt_sel_pkg::FIELD_ALT);
		next_fo.hold_alt = (field == filt_sel_pkg::FIELD_DATA);
	end
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			fo <= '{7'h00, 3'h0, 5'h0B, 1'b0, 1'b0, 1'b1};
			o_cutoff_code <= 7'h00;
			o_slim_code <= 3'h0;
			o_peak_idx <= 3'h7;
			o_k_ratio <= 5'h0B;
			o_data_gain_ctrl_pin <= 1'b1;
			o_alt_field_gain_ctrl_pin <= 1'b0;
			o_data_gain_hold <= 1'b0;
			o_alt_field_gain_hold <= 1'b1;
		end else begin
			fo <= next_fo;
			o_cutoff_code <= next_fo.cutoff_code;
			o_slim_code <= next_fo.slim_code;
			o_peak_idx <= dec_peak;
			o_k_ratio <= next_fo.k_ratio;
			o_data_gain_ctrl_pin <= !next_fo.gain_sel_alt;
			o_alt_field_gain_ctrl_pin <= next_fo.gain_sel_alt;
			o_data_gain_hold <= next_fo.hold_data;
			o_alt_field_gain_hold <= next_fo.hold_alt;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Checks.
	a_data_k_floor: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(o_data_gain_ctrl_pin |-> o_k_ratio >= `K_MIN_DATA))
		else $error("data field ratio below floor");
	a_gain_one_hot: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(o_data_gain_ctrl_pin != o_alt_field_gain_ctrl_pin))
		else $error("gain select not exclusive");
	a_hold_pairs: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(o_data_gain_hold == o_alt_field_gain_ctrl_pin))
		else $error("hold does not match select");
	a_pin_to_gain: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		($rose(fs_sync) |=> o_alt_field_gain_ctrl_pin))
		else $error("servo field not steered");
	a_alt_code: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(alt_active |=> o_slim_code == $past(ctrl[15:13])))
		else $error("servo code not applied");
	a_data_code: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(!ctrl[12] |=> o_slim_code == $past(ctrl[9:7])))
		else $error("data code not applied when disabled");
	a_cutoff_pass: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(1'b1 |=> o_cutoff_code == $past(ctrl[6:0])))
		else $error("cutoff code mismatch");
	a_peak_mono: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(1'b1 |=> o_peak_idx == 3'h7 - o_slim_code))
		else $error("peaking decode wrong");
	a_switch_pin: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(ctrl[12] && $changed(fs_sync) && $stable(ctrl)
		|=> $changed(o_slim_code) || ctrl[15:13] == ctrl[9:7]))
		else $error("pin change did not switch code");
	a_ack_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(o_wb_ack |=> !o_wb_ack))
		else $error("ack longer than one cycle");
	a_ack_follows: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		((i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack))
		else $error("request not acknowledged");
	a_write_lands: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		((i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack && i_wb_sel == 4'hF
		&& i_wb_adr == `REG_CTRL_ADDR) |=> ctrl == $past(i_wb_dat)))
		else $error("control write lost");
	a_alt_k_zero: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(alt_active |=> o_k_ratio == {2'h0, o_peak_idx}))
		else $error("servo ratio not unfloored");
	a_data_k_step: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(!alt_active |=> o_k_ratio == 5'(`K_MIN_DATA + {2'h0, o_peak_idx})))
		else $error("data ratio not above floor");
	a_servo_peak: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(alt_active |=> o_peak_idx == 3'h7 - $past(ctrl[`ALT_SLIM_MSB:`ALT_SLIM_LSB])))
		else $error("servo peaking decode wrong");
	a_hold_data_off: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(o_data_gain_ctrl_pin |-> !o_data_gain_hold))
		else $error("selected data gain held");
	a_hold_alt_off: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(o_alt_field_gain_ctrl_pin |-> !o_alt_field_gain_hold))
		else $error("selected servo gain held");
	a_gain_follows: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(1'b1 |=> o_alt_field_gain_ctrl_pin == $past(fs_sync)))
		else $error("gain select not following pin");
	a_fall_to_data: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		($fell(fs_sync) |=> o_data_gain_ctrl_pin))
		else $error("data field not steered");
	a_pin_low_data: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(!fs_sync |=> o_slim_code == $past(ctrl[`DATA_SLIM_MSB:`DATA_SLIM_LSB])))
		else $error("data field code not applied");
	a_stat_read: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		((i_wb_cyc && i_wb_stb && !i_wb_we && !o_wb_ack && i_wb_adr == `REG_STAT_ADDR)
		|=> o_wb_dat == {14'h0000, $past(fo)}))
		else $error("status read wrong");
endmodule : filt_field_sel

// file: hw/filt_sel_params.svh
// Offsets, field positions, reset values and decode constants for the filter field select block.
`ifndef FILT_SEL_PARAMS_SVH
`define FILT_SEL_PARAMS_SVH
`define REG_CTRL_ADDR 8'h00
`define REG_STAT_ADDR 8'h04
`define CUTOFF_LSB 0
`define CUTOFF_MSB 6
`define DATA_SLIM_LSB 7
`define DATA_SLIM_MSB 9
`define ALT_SLIM_LSB 13
`define ALT_SLIM_MSB 15
`define SWITCH_EN_BIT 12
`define CTRL_RESET 32'h0000_0000
`define CUTOFF_STEPS 128
`define SLIM_NONE 3'h7
`define K_MIN_DATA 5'h0_04
`endif

// file: hw/filt_sel_pkg.sv
// Types shared by the filter field select block.
package filt_sel_pkg;
	typedef struct packed {
		logic [6:0] cutoff_code;
		logic [2:0] slim_code;
		logic [4:0] k_ratio;
		logic gain_sel_alt;
		logic hold_data;
		logic hold_alt;
	} filt_out_t;
	typedef enum logic [1:0] {
		FIELD_DATA = 2'b01,
		FIELD_ALT = 2'b10
	} field_t;
endpackage : filt_sel_pkg

// file: hw/slim_decode.sv
// Slimming code to peaking index and injection ratio decode.
`include "filt_sel_params.svh"
module slim_decode (
	input wire logic [2:0] i_code,
	input wire logic i_allow_zero,
	output logic [2:0] o_peak_idx,
	output logic [4:0] o_k_ratio
);
	always_comb begin
		o_peak_idx = 3'h7 - i_code;
		if (i_allow_zero) begin
			o_k_ratio = {2'h0, o_peak_idx};
		end else begin
			o_k_ratio = 5'(`K_MIN_DATA + {2'h0, o_peak_idx});
		end
	end
endmodule : slim_decode

// file: dv/field_ctrl_model.sv
// Drive controller model that marks servo regions on the field select pin.
module field_ctrl_model (
	input wire logic i_clk,
	input wire logic i_servo_req,
	output logic o_field_select_pin = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	always @(posedge i_clk) begin
		o_field_select_pin <= i_servo_req;
	end
endmodule : field_ctrl_model

// file: dv/tb_top.sv
// Self-checking bench for the filter field select block.
`include "filt_sel_params.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_b, req, pin, cyc, stb, we, ack, dg, ag, dh, ah;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat;
	logic [6:0] cutoff;
	logic [2:0] slim, peak;
	logic [4:0] k;
	int bad_count = 0;
	int checked = 0;
	field_ctrl_model i_ctrl (.i_clk(clk), .i_servo_req(req), .o_field_select_pin(pin));
	filt_field_sel i_dut (.i_clk(clk), .i_rst_b(rst_b), .i_field_select_pin(pin),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
		.i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .o_cutoff_code(cutoff),
		.o_slim_code(slim), .o_peak_idx(peak), .o_k_ratio(k), .o_data_gain_ctrl_pin(dg),
		.o_alt_field_gain_ctrl_pin(ag), .o_data_gain_hold(dh), .o_alt_field_gain_hold(ah));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] q);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		do @(posedge clk); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task automatic t_reg;
		logic [31:0] q;
		wb(1'b1, `REG_CTRL_ADDR, 32'h0000_F07F, 4'hF, q);
		wb(1'b0, `REG_CTRL_ADDR, 32'h0000_0000, 4'hF, q);
		`CHK(q, 32'h0000_F07F) // enable bit stored.
		repeat (4) @(posedge clk);
		`CHK(cutoff, 7'h7F) // top cutoff step.
		wb(1'b1, 8'h08, 32'hFFFF_FFFF, 4'hF, q);
		wb(1'b0, 8'h08, 32'h0000_0000, 4'hF, q);
		`CHK(q, 32'h0000_0000)
		wb(1'b1, `REG_CTRL_ADDR, 32'h0000_0000, 4'h2, q);
		wb(1'b0, `REG_CTRL_ADDR, 32'h0000_0000, 4'hF, q);
		`CHK(q, 32'h0000_007F)
	endtask : t_reg
	task automatic t_field;
		logic [31:0] q;
		logic en, p;
		logic [2:0] c, x;
		logic [4:0] ke;
		for (int i = 0; i < 16; i++) begin
			en = i[3];
			c = i[2:0];
			wb(1'b1, `REG_CTRL_ADDR, {16'h0000, ~c, en, 2'b00, c, i[3:0], 3'h5}, 4'hF, q);
			for (int j = 0; j < 3; j++) begin
				p = j[0];
				req <= p;
				repeat (5) @(posedge clk);
				x = (en && p) ? ~c : c;
				ke = (en && p) ? {2'b00, 3'h7 - x} : 5'(`K_MIN_DATA + {2'b00, 3'h7 - x});
				`CHK(cutoff, {i[3:0], 3'h5}) // cutoff as written.
				`CHK(slim, x) // pin selects code.
				`CHK(peak, 3'h7 - x) // peaking order.
				`CHK(k, ke)
				`CHK({dg, ag, dh, ah}, {~p, p, p, ~p})
				wb(1'b0, `REG_STAT_ADDR, 32'h0000_0000, 4'hF, q);
				`CHK(q, {14'h0000, i[3:0], 3'h5, x, ke, p, p, ~p})
			end
		end
	endtask : t_field
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : print_verdict
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#(100 * 5000);
		bad_count++;
		$display("unexpected at %0t: watchdog expired", $time);
		print_verdict();
	end
	initial begin
		{rst_b, req, cyc, stb, we} = 5'h00;
		adr = 8'h00;
		sel = 4'h0;
		wdat = 32'h0000_0000;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		t_reg();
		t_field();
		print_verdict();
	end
endmodule : tb_top
